/* File: fws_pkg.sv */
package fws_pkg;
  // Software register map, word aligned byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // Control field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_OP_HI = 3;
  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_READY = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_WIN = 5;
  // Data bit positions
  localparam int BIT_POLL = 7;
  localparam int BIT_ANY = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WIN = 3;
  localparam int BIT_SECT = 2;
  // Flash command codes
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h0_0555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h0_02AA;
  // Bus strobe timing
  localparam int T_STROBE_NS = 100;
  localparam int CLK_NS = 20;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_POLL = 3'b010,
    OP_TOGGLE = 3'b011,
    OP_SUSPEND = 3'b100,
    OP_RESUME = 3'b101,
    OP_AUTOSEL = 3'b110,
    OP_RESET = 3'b111
  } fws_op_e;
endpackage

/* File: fws_cyc_if.sv */
`timescale 1ns/1ps
interface fws_cyc_if;
  logic start;
  logic wr;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl (output start, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* File: fws_bus_cycle.sv */
`timescale 1ns/1ps
module fws_bus_cycle (
  input wire logic clk,
  input wire logic rst,
  fws_cyc_if.eng cyc,
  input wire logic [7:0] dq_in_sync,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] addr,
  output logic [7:0] dq_out,
  output logic dq_oe_n
);
  localparam logic [3:0] STROBE_LAST = 4'(fws_pkg::STROBE_CYC + 2);
  logic [3:0] cnt;
  logic active;
  logic wr;

  ////////////////////////////////////////////////////////////////////
  // One strobe per cycle; sync delay covered by extra counts
  always_ff @(posedge clk) begin
    if (rst) begin
      active <= 1'b0;
      cnt <= 4'h0;
      wr <= 1'b0;
    end else if (!active && cyc.start) begin
      active <= 1'b1;
      cnt <= 4'h0;
      wr <= cyc.wr;
    end else if (active) begin
      cnt <= cnt + 4'h1;
      if (cnt == STROBE_LAST) begin
        active <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 20'h0_0000;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else if (!active && cyc.start) begin
      ce_n <= 1'b0;
      addr <= cyc.addr;
      dq_out <= cyc.wdata;
      dq_oe_n <= !cyc.wr;
      oe_n <= cyc.wr;
      we_n <= !cyc.wr;
    end else if (active && cnt == STROBE_LAST) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe_n <= 1'b1;
    end
  end

  // Each read is one full chip select and output enable pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= active && cnt == STROBE_LAST;
      if (active && cnt == STROBE_LAST && !wr) begin
        cyc.rdata <= dq_in_sync;
      end
    end
  end
endmodule

/* File: fws_ctrl.sv */
`timescale 1ns/1ps
module fws_ctrl (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic [19:0] FL_ADDR,
  input wire logic [7:0] FL_DQ_IN,
  output logic [7:0] FL_DQ_OUT,
  output logic FL_DQ_OE_N,
  input wire logic FL_DONE_LINE_N
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CMD = 4'b0001,
    S_RD1 = 4'b0010,
    S_RD2 = 4'b0011,
    S_CHK = 4'b0100,
    S_RD3 = 4'b0101,
    S_RECHK = 4'b0110,
    S_FIN = 4'b0111,
    S_WAIT = 4'b1000
  } fws_state_e;

  fws_state_e state;
  fws_cyc_if cyc ();
  logic [3:0] op;
  logic [19:0] reg_addr;
  logic [7:0] reg_data;
  logic [7:0] last_rd;
  logic [7:0] first_rd;
  logic [2:0] seq_idx;
  logic [2:0] seq_len;
  logic busy, done_f, fail_f, susp_f, win_f;
  logic [7:0] dq_m, dq_s;
  logic rb_m, rb_s;
  logic issued;

  ////////////////////////////////////////////////////////////////////
  // Two flop synchronisers for pins
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      dq_m <= 8'h00;
      dq_s <= 8'h00;
      rb_m <= 1'b1;
      rb_s <= 1'b1;
    end else begin
      dq_m <= FL_DQ_IN;
      dq_s <= dq_m;
      rb_m <= FL_DONE_LINE_N;
      rb_s <= rb_m;
    end
  end

  fws_bus_cycle u_cyc (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .cyc(cyc.eng),
    .dq_in_sync(dq_s),
    .ce_n(FL_CE_N),
    .oe_n(FL_OE_N),
    .we_n(FL_WE_N),
    .addr(FL_ADDR),
    .dq_out(FL_DQ_OUT),
    .dq_oe_n(FL_DQ_OE_N)
  );

  ////////////////////////////////////////////////////////////////////
  // Command sequence steps: address and data of step i
  function automatic logic [27:0] seq_step(input logic [2:0] o, input logic [2:0] i,
                                           input logic [19:0] a, input logic [7:0] d);
    logic [27:0] r;
    r = {a, d};
    case (o)
      fws_pkg::OP_SUSPEND: r = {a, fws_pkg::CMD_SUSPEND};
      fws_pkg::OP_RESUME: r = {a, fws_pkg::CMD_RESUME};
      fws_pkg::OP_RESET: r = {a, fws_pkg::CMD_RESET};
      fws_pkg::OP_AUTOSEL: begin
        if (i == 3'd0) begin
          r = {fws_pkg::ADDR_UNLOCK1, fws_pkg::CMD_UNLOCK1};
        end else if (i == 3'd1) begin
          r = {fws_pkg::ADDR_UNLOCK2, fws_pkg::CMD_UNLOCK2};
        end else begin
          r = {fws_pkg::ADDR_UNLOCK1, fws_pkg::CMD_AUTOSEL};
        end
      end
      default: r = {a, d};
    endcase
    return r;
  endfunction

  function automatic logic [2:0] seq_count(input logic [2:0] o);
    return (o == fws_pkg::OP_AUTOSEL) ? 3'd3 : 3'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Avalon slave, one wait cycle on every access
  logic acc_pend;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      acc_pend <= 1'b0;
    end else begin
      acc_pend <= (AVS_READ || AVS_WRITE) && !acc_pend;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !acc_pend);
    end
  end

  logic take_wr;
  assign take_wr = AVS_WRITE && acc_pend && !AVS_WAITREQUEST;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      reg_addr <= 20'h0_0000;
      reg_data <= 8'h00;
    end else if (take_wr && AVS_ADDRESS == fws_pkg::REG_ADDR) begin
      reg_addr <= AVS_WRITEDATA[19:0];
    end else if (take_wr && AVS_ADDRESS == fws_pkg::REG_DATA) begin
      reg_data <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      case (AVS_ADDRESS)
        fws_pkg::REG_CTRL: AVS_READDATA <= {28'h000_0000, op};
        fws_pkg::REG_ADDR: AVS_READDATA <= {12'h000, reg_addr};
        fws_pkg::REG_DATA: AVS_READDATA <= {24'h00_0000, last_rd};
        fws_pkg::REG_STAT: AVS_READDATA <= {26'h000_0000, win_f, susp_f, rb_s, fail_f, done_f, busy};
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operation sequencer
  logic go;
  assign go = take_wr && AVS_ADDRESS == fws_pkg::REG_CTRL && AVS_WRITEDATA[fws_pkg::CTRL_GO] && !busy;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= S_IDLE;
      op <= 4'h0;
      busy <= 1'b0;
      done_f <= 1'b0;
      fail_f <= 1'b0;
      seq_idx <= 3'd0;
      seq_len <= 3'd0;
      issued <= 1'b0;
      last_rd <= 8'h00;
      first_rd <= 8'h00;
    end else begin
      issued <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go) begin
            op <= {1'b0, AVS_WRITEDATA[fws_pkg::CTRL_OP_HI:fws_pkg::CTRL_OP_LO]};
            busy <= 1'b1;
            done_f <= 1'b0;
            fail_f <= 1'b0;
            seq_idx <= 3'd0;
            seq_len <= seq_count(AVS_WRITEDATA[fws_pkg::CTRL_OP_HI:fws_pkg::CTRL_OP_LO]);
            issued <= 1'b1;
            case (AVS_WRITEDATA[fws_pkg::CTRL_OP_HI:fws_pkg::CTRL_OP_LO])
              fws_pkg::OP_READ, fws_pkg::OP_POLL, fws_pkg::OP_TOGGLE: state <= S_RD1;
              default: state <= S_CMD;
            endcase
          end
        end
        S_CMD: begin
          if (cyc.done) begin
            if (seq_idx + 3'd1 == seq_len) begin
              state <= S_FIN;
            end else begin
              seq_idx <= seq_idx + 3'd1;
              issued <= 1'b1;
            end
          end
        end
        S_RD1: begin
          if (cyc.done) begin
            first_rd <= cyc.rdata;
            last_rd <= cyc.rdata;
            if (op[2:0] == fws_pkg::OP_READ) begin
              state <= S_FIN;
            end else if (op[2:0] == fws_pkg::OP_POLL) begin
              // expected bit seven is true data
              if (cyc.rdata[fws_pkg::BIT_POLL] == reg_data[fws_pkg::BIT_POLL]) begin
                state <= S_RD3;
                issued <= 1'b1;
              end else if (cyc.rdata[fws_pkg::BIT_FAIL]) begin
                state <= S_RD2;
                issued <= 1'b1;
              end else begin
                issued <= 1'b1;
              end
            end else begin
              state <= S_RD2;
              issued <= 1'b1;
            end
          end
        end
        S_RD2: begin
          if (cyc.done) begin
            last_rd <= cyc.rdata;
            if (op[2:0] == fws_pkg::OP_POLL) begin
              // Recheck after fail bit seen
              fail_f <= cyc.rdata[fws_pkg::BIT_POLL] != reg_data[fws_pkg::BIT_POLL];
              state <= S_FIN;
            end else if (cyc.rdata[fws_pkg::BIT_ANY] == first_rd[fws_pkg::BIT_ANY]) begin
              state <= S_RD3;
              issued <= 1'b1;
            end else if (cyc.rdata[fws_pkg::BIT_FAIL]) begin
              first_rd <= cyc.rdata;
              state <= S_RECHK;
              issued <= 1'b1;
            end else begin
              first_rd <= cyc.rdata;
              issued <= 1'b1;
            end
          end
        end
        S_RECHK: begin
          if (cyc.done) begin
            last_rd <= cyc.rdata;
            fail_f <= cyc.rdata[fws_pkg::BIT_ANY] != first_rd[fws_pkg::BIT_ANY];
            state <= S_FIN;
          end
        end
        S_RD3: begin
          if (cyc.done) begin
            last_rd <= cyc.rdata;
            state <= S_FIN;
          end
        end
        S_FIN: begin
          busy <= 1'b0;
          done_f <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Suspend and erase window tracking for status
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      susp_f <= 1'b0;
      win_f <= 1'b0;
    end else begin
      if (state == S_FIN && op[2:0] == fws_pkg::OP_SUSPEND) begin
        susp_f <= 1'b1;
      end else if (state == S_FIN && (op[2:0] == fws_pkg::OP_RESUME || op[2:0] == fws_pkg::OP_RESET)) begin
        susp_f <= 1'b0;
      end
      if (state == S_RD1 && cyc.done) begin
        win_f <= cyc.rdata[fws_pkg::BIT_WIN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Cycle requests
  logic [27:0] step;
  assign step = seq_step(op[2:0], seq_idx, reg_addr, reg_data);
  assign cyc.start = issued;
  assign cyc.wr = (state == S_CMD);
  assign cyc.addr = (state == S_CMD) ? step[27:8] : reg_addr;
  assign cyc.wdata = (state == S_CMD) ? step[7:0] : 8'h00;
endmodule

/* File: fws_ctrl_asserts.sv */
`timescale 1ns/1ps
module fws_ctrl_chk (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic [19:0] FL_ADDR,
  input wire logic FL_DQ_OE_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  a_strobe_excl: assert property (FL_OE_N || FL_WE_N) else $error("both strobes low");
  a_read_sel: assert property (!FL_OE_N |-> !FL_CE_N) else $error("read without select");
  a_write_sel: assert property (!FL_WE_N |-> !FL_CE_N && !FL_DQ_OE_N) else $error("write not driven");
  a_read_float: assert property (!FL_OE_N |-> FL_DQ_OE_N) else $error("data driven in read");
  a_read_width: assert property ($fell(FL_OE_N) |-> !FL_OE_N [*5]) else $error("read pulse short");
  a_write_width: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*5]) else $error("write pulse short");
  a_addr_stable: assert property (!FL_OE_N && !$past(FL_OE_N) |-> $stable(FL_ADDR))
    else $error("address moved in read");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no bus answer");
  a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[1:0] != 2'h0
    |-> AVS_READDATA == 32'h0000_0000) else $error("unmapped read not zero");
  c_flash_write: cover property ($fell(FL_WE_N));
  c_flash_read: cover property ($fell(FL_OE_N));
  c_stat_read: cover property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'hC);
endmodule
bind fws_ctrl fws_ctrl_chk u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_ADDR(FL_ADDR), .FL_DQ_OE_N(FL_DQ_OE_N));

/* File: fws_flash_model.sv */
`timescale 1ns/1ps
module fws_flash_model #(
  parameter int PLEN = 3,
  parameter int ELEN = 6,
  parameter logic [7:0] ID = 8'h5A
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [7:0] dq_w,
  input wire logic erase_go,
  input wire logic [3:0] er_sect,
  input wire logic fail_mode,
  output logic [7:0] dq_r,
  output logic done_n
);
  // ID value is arbitrary
  logic [7:0] mem [16];
  logic [7:0] pd, last;
  logic [3:0] pa, es;
  logic t6, t2, pgm, ers, sus, asel, f5, wsel;
  int pl, el;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {pd, last, pa, es, t6, t2, pgm, ers, sus, asel, f5, wsel} = 0;
  end
  // Write marked while both strobes low; select and strobe rise together
  always @(negedge we_n or negedge ce_n) if (!ce_n && !we_n) wsel = 1;
  // Commands take effect at the end of the write strobe
  always @(posedge we_n or posedge ce_n) if (wsel) begin
    wsel = 0;
    case (dq_w)
      8'hF0: begin
        if (!asel) {pgm, ers, sus, f5} = 0;
        asel = 0;
      end
      8'hB0: sus = ers;
      8'h30: sus = 0;
      8'h90: asel = sus;
      8'hAA, 8'h55: ;
      default: begin
        pgm = 1;
        pa = addr[3:0];
        pd = dq_w;
        pl = PLEN;
        f5 = fail_mode;
      end
    endcase
  end
  always @(posedge erase_go) begin
    ers = 1;
    sus = 0;
    es = er_sect;
    el = ELEN;
  end
  // One advance per read strobe
  always @(negedge oe_n) if (!ce_n) begin
    if (pgm || ers && !sus) t6 = !t6;
    if (ers && addr[19:16] == es) t2 = !t2;
    if (pgm && !f5) pl = pl - 1;
    else if (ers && !sus) el = el - 1;
    if (pgm && pl == 0) mem[pa] = pd;
    if (pgm && pl == 0) pgm = 0;
    if (ers && el == 0) ers = 0;
  end
  always @(dq_r) if (!ce_n && !oe_n) last = dq_r;
  always_comb begin
    if (ce_n || oe_n) dq_r = ~last;
    else if (asel) dq_r = ID;
    else if (pgm) dq_r = {~pd[7], t6, f5, 5'h00};
    else if (ers && addr[19:16] == es) dq_r = {sus, t6, 3'h1, t2, 2'h0};
    else dq_r = mem[addr[3:0]];
  end
  assign done_n = !(pgm || ers && !sus);
endmodule

/* File: tb_flash_write_status_report.sv */
`timescale 1ns/1ps
module tb_flash_write_status_report;
  logic CLK_SYS, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, FL_CE_N, FL_OE_N, FL_WE_N, FL_DQ_OE_N;
  logic [3:0] AVS_ADDRESS, er_sect;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [19:0] FL_ADDR;
  logic [7:0] FL_DQ_IN, FL_DQ_OUT;
  logic done_n, erase_go, fail_mode, b2, b6;
  int fail_count, n_checks, cyc;
  fws_ctrl dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
    .FL_ADDR(FL_ADDR), .FL_DQ_IN(FL_DQ_IN), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE_N(FL_DQ_OE_N),
    .FL_DONE_LINE_N(done_n));
  fws_flash_model flash (.ce_n(FL_CE_N), .oe_n(FL_OE_N), .we_n(FL_WE_N), .addr(FL_ADDR), .dq_w(FL_DQ_OUT),
    .erase_go(erase_go), .er_sect(er_sect), .fail_mode(fail_mode), .dq_r(FL_DQ_IN), .done_n(done_n));
  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CLK_SYS);
    end
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic run(input fws_pkg::fws_op_e op);
    wr(fws_pkg::REG_CTRL, {28'h000_0000, op, 1'b1});
    do begin
      rd(fws_pkg::REG_STAT);
    end while (q[fws_pkg::ST_BUSY] !== 1'b0);
  endtask
  task automatic prog(input logic [31:0] a, input logic [31:0] d);
    wr(fws_pkg::REG_ADDR, a);
    wr(fws_pkg::REG_DATA, d);
    run(fws_pkg::OP_WRITE);
  endtask
  task automatic fin(input logic [7:0] d);
    rd(fws_pkg::REG_STAT);
    chk(q[2:1], 2'h1);
    rd(fws_pkg::REG_DATA);
    chk(q[7:0], d);
  endtask
  initial begin
    CLK_SYS = 0;
    SYS_RST = 1;
    {AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA, erase_go, fail_mode} = 0;
    er_sect = 4'h1;
    repeat (10) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(fws_pkg::REG_STAT);
    chk(q[4:0], 5'h08);
    rd(4'h2);
    chk(q, 32'h0000_0000);
    prog(32'h0000_0005, 32'h0000_00A5);
    run(fws_pkg::OP_POLL);
    fin(8'hA5);
    rd(fws_pkg::REG_CTRL);
    chk(q[2:0], fws_pkg::OP_POLL);
    prog(32'h0000_0006, 32'h0000_003C);
    rd(fws_pkg::REG_STAT);
    chk(q[fws_pkg::ST_READY], 1'b0);
    run(fws_pkg::OP_TOGGLE);
    fin(8'h3C);
    fail_mode <= 1'b1;
    prog(32'h0000_0002, 32'h0000_0011);
    run(fws_pkg::OP_TOGGLE);
    rd(fws_pkg::REG_STAT);
    chk(q[fws_pkg::ST_FAIL], 1'b1);
    fail_mode <= 1'b0;
    run(fws_pkg::OP_RESET);
    run(fws_pkg::OP_READ);
    rd(fws_pkg::REG_DATA);
    chk(q[7:0], 8'hFF);
    wr(fws_pkg::REG_ADDR, 32'h0001_0007);
    erase_go <= 1'b1;
    @(posedge CLK_SYS);
    erase_go <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    rd(fws_pkg::REG_STAT);
    chk(q[fws_pkg::ST_READY], 1'b0);
    run(fws_pkg::OP_SUSPEND);
    rd(fws_pkg::REG_STAT);
    chk(q[fws_pkg::ST_READY], 1'b1);
    run(fws_pkg::OP_READ);
    rd(fws_pkg::REG_DATA);
    chk({q[7], q[3]}, 2'h3);
    b2 = q[2];
    b6 = q[6];
    run(fws_pkg::OP_READ);
    rd(fws_pkg::REG_DATA);
    chk({q[6], q[2]}, {b6, ~b2});
    run(fws_pkg::OP_AUTOSEL);
    run(fws_pkg::OP_READ);
    rd(fws_pkg::REG_DATA);
    chk(q[7:0], 8'h5A);
    run(fws_pkg::OP_RESET);
    run(fws_pkg::OP_RESUME);
    run(fws_pkg::OP_RESUME);
    rd(fws_pkg::REG_STAT);
    chk(q[fws_pkg::ST_READY], 1'b0);
    wr(fws_pkg::REG_DATA, 32'h0000_0080);
    run(fws_pkg::OP_POLL);
    fin(8'hFF);
    results();
  end
endmodule
